/* core/rwa_map.vh */
// Behaviour
// R01 - Loss-of-lock invalid group count programmable from 1 to 64.
// R02 - Run of 1 to 256 good groups lowers error count by one.
// R03 - After reset release, hunt for comma or its complement.
// R04 - Locked goes high after programmed count of valid sync groups.
// R05 - Locked stays high until the error count reaches the programmed invalid group count.
// R06 - After loss, locked stays low until sync groups are seen again.
// R07 - Count equal consecutive bits; flag when count reaches threshold.
// R08 - Run-length flag held at least two recovered word clocks.
// R09 - Threshold 4..128 step 4 (8-bit) or 5..160 step 5 (10-bit).
// R10 - Rate matcher absorbs up to 300 ppm each way.
// R11 - Local clock faster: insert skip groups.
// R12 - Local clock slower: delete skip groups.
// R13 - Twenty-word buffer; fill level decides insert or delete.
// R14 - Rate matching starts only once aligner is locked.
// R15 - Rate matching only with 8b/10b and automatic sync mode.
// R16 - Decode 10-bit group to byte plus control flag.
// R17 - Decode tables follow the standard Ethernet 8b/10b code.
// R18 - Per-byte skip deleted and skip inserted status outputs.
// R19 - Invalid group raises error count; count floors at zero.
// R20 - Skip pattern is a parameter; skips are deleted or inserted one group at a time.
`ifndef RWA_MAP_VH
`define RWA_MAP_VH

`define RWA_ADDR_CTRL 4'h0
`define RWA_ADDR_STAT 4'h4
`define RWA_CTRL_RST 32'h03FC_83C3
`define RWA_F_LOSS 5:0
`define RWA_F_GOOD 13:6
`define RWA_F_ACQ 17:14
`define RWA_F_RLV 22:18
`define RWA_B_W10 23
`define RWA_B_ENC 24
`define RWA_B_AUTO 25

`define RWA_COMMA 7'h1F
`define RWA_COMMA_N 7'h60
`define RWA_SKIP 10'h0F4
`define RWA_DEPTH 20
`define RWA_HI_MARK 5'h0E
`define RWA_LO_MARK 5'h06
`define RWA_RLV_HOLD 2'h2

`define RWA_CLK_NS 100
`define RWA_WORD_NS 800
`define RWA_WORD_DIV (`RWA_WORD_NS / `RWA_CLK_NS)

`endif

/* core/rwa_dec_8b10b.v */
`timescale 1ns/1ps
`include "rwa_map.vh"

module rwa_dec_8b10b (
  input wire [9:0] code,
  output reg [7:0] data,
  output reg ctrl,
  output reg err
);

  reg [5:0] v5;
  reg [3:0] v3;

  always @*
  begin
    v5 = 6'h3F;
    case (code[9:4]) // see R16 see R17
      6'b100111, 6'b011000: v5 = 6'd0;
      6'b011101, 6'b100010: v5 = 6'd1;
      6'b101101, 6'b010010: v5 = 6'd2;
      6'b110001: v5 = 6'd3;
      6'b110101, 6'b001010: v5 = 6'd4;
      6'b101001: v5 = 6'd5;
      6'b011001: v5 = 6'd6;
      6'b111000, 6'b000111: v5 = 6'd7;
      6'b111001, 6'b000110: v5 = 6'd8;
      6'b100101: v5 = 6'd9;
      6'b010101: v5 = 6'd10;
      6'b110100: v5 = 6'd11;
      6'b001101: v5 = 6'd12;
      6'b101100: v5 = 6'd13;
      6'b011100: v5 = 6'd14;
      6'b010111, 6'b101000: v5 = 6'd15;
      6'b011011, 6'b100100: v5 = 6'd16;
      6'b100011: v5 = 6'd17;
      6'b010011: v5 = 6'd18;
      6'b110010: v5 = 6'd19;
      6'b001011: v5 = 6'd20;
      6'b101010: v5 = 6'd21;
      6'b011010: v5 = 6'd22;
      6'b111010, 6'b000101: v5 = 6'd23;
      6'b110011, 6'b001100: v5 = 6'd24;
      6'b100110: v5 = 6'd25;
      6'b010110: v5 = 6'd26;
      6'b110110, 6'b001001: v5 = 6'd27;
      6'b001110, 6'b001111, 6'b110000: v5 = 6'd28;
      6'b101110, 6'b010001: v5 = 6'd29;
      6'b011110, 6'b100001: v5 = 6'd30;
      6'b101011, 6'b010100: v5 = 6'd31;
      default: v5 = 6'h3F;
    endcase
    case (code[3:0])
      4'b1011, 4'b0100: v3 = 4'd0;
      4'b1001: v3 = 4'd1;
      4'b0101: v3 = 4'd2;
      4'b1100, 4'b0011: v3 = 4'd3;
      4'b1101, 4'b0010: v3 = 4'd4;
      4'b1010: v3 = 4'd5;
      4'b0110: v3 = 4'd6;
      4'b1110, 4'b0001, 4'b0111, 4'b1000: v3 = 4'd7;
      default: v3 = 4'hF;
    endcase
    ctrl = (code[9:4] == 6'b001111) || (code[9:4] == 6'b110000) ||
      ((code[3:0] == 4'b1000 || code[3:0] == 4'b0111) &&
      (v5 == 6'd23 || v5 == 6'd27 || v5 == 6'd29 || v5 == 6'd30));
    err = v5[5] | v3[3];
    data = {v3[2:0], v5[4:0]};
  end

endmodule // rwa_dec_8b10b

/* core/rwa_top.v */
`timescale 1ns/1ps
`include "rwa_map.vh"

module rwa_top #(
  parameter DEPTH = `RWA_DEPTH,
  parameter WORD_DIV = `RWA_WORD_DIV,
  parameter [9:0] SKIP_CODE = `RWA_SKIP
) (
  input wire clk,
  input wire reset,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire rx_rclk,
  input wire [9:0] rx_code,
  output reg [7:0] rx_data,
  output reg rx_ctrl,
  output reg rx_err,
  output reg rx_valid,
  output reg rx_locked,
  output reg rx_runlen,
  output reg rx_skip_del,
  output reg rx_skip_ins
);

  localparam ST_HUNT = 2'd0;
  localparam ST_ACQ = 2'd1;
  localparam ST_LOCK = 2'd2;

  ////////////////////////////////////////////////////////////////////////
  // Register slave

  reg [31:0] ctrl_r;
  reg [1:0] state_r;
  reg [6:0] errc_r;
  reg [4:0] level_r;
  integer b;

  wire bus_req = avs_read | avs_write;
  wire bus_done = bus_req & ~avs_waitrequest;

  always @(posedge clk)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ctrl_r <= `RWA_CTRL_RST;
    end
    else
    begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest)
      begin
        case (avs_address)
          `RWA_ADDR_CTRL: avs_readdata <= ctrl_r;
          `RWA_ADDR_STAT: avs_readdata <= {16'h0000, state_r, errc_r,
            level_r, rx_runlen, rx_locked};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (bus_done & avs_write & (avs_address == `RWA_ADDR_CTRL))
      begin
        for (b = 0; b < 4; b = b + 1)
        begin
          if (avs_byteenable[b])
            ctrl_r[b*8 +: 8] <= avs_writedata[b*8 +: 8];
        end
      end
    end
  end

  wire [6:0] loss_thr = {1'b0, ctrl_r[`RWA_F_LOSS]} + 7'd1; // see R01
  wire [8:0] good_thr = {1'b0, ctrl_r[`RWA_F_GOOD]} + 9'd1; // see R02
  wire [4:0] acq_thr = {1'b0, ctrl_r[`RWA_F_ACQ]} + 5'd1;
  wire w10 = ctrl_r[`RWA_B_W10];
  wire rm_en = ctrl_r[`RWA_B_ENC] & ctrl_r[`RWA_B_AUTO]; // see R15

  ////////////////////////////////////////////////////////////////////////
  // Link sampling

  reg [2:0] rclk_sync_r;
  reg [9:0] code_s1_r;
  reg [9:0] code_s2_r;
  reg [9:0] prev_r;
  wire word_ev = rclk_sync_r[1] & ~rclk_sync_r[2];

  always @(posedge clk)
  begin
    if (reset)
    begin
      rclk_sync_r <= 3'b000;
      code_s1_r <= 10'h000;
      code_s2_r <= 10'h000;
      prev_r <= 10'h000;
    end
    else
    begin
      rclk_sync_r <= {rclk_sync_r[1:0], rx_rclk};
      code_s1_r <= rx_code;
      code_s2_r <= code_s1_r;
      if (word_ev)
        prev_r <= code_s2_r;
    end
  end

  wire [19:0] win = {prev_r, code_s2_r};

  ////////////////////////////////////////////////////////////////////////
  // Comma search and sync machine

  reg [3:0] off_r;
  reg [3:0] hit_off;
  reg hit_any;
  integer k;

  always @*
  begin
    hit_any = 1'b0;
    hit_off = 4'h0;
    for (k = 9; k >= 0; k = k - 1)
    begin
      if (win[9+k -: 7] == `RWA_COMMA || win[9+k -: 7] == `RWA_COMMA_N)
      begin
        hit_any = 1'b1;
        hit_off = k[3:0];
      end
    end
  end

  wire [9:0] grp = win[9+off_r -: 10];
  wire grp_comma = (grp[9:3] == `RWA_COMMA) || (grp[9:3] == `RWA_COMMA_N);
  wire grp_bad;

  rwa_dec_8b10b u_chk (
    .code(grp),
    .data(),
    .ctrl(),
    .err(grp_bad)
  );

  reg [4:0] acq_r;
  reg [8:0] good_r;

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= ST_HUNT;
      off_r <= 4'h0;
      acq_r <= 5'h00;
      good_r <= 9'h000;
      errc_r <= 7'h00;
      rx_locked <= 1'b0;
    end
    else if (word_ev)
    begin
      case (state_r)
        ST_HUNT:
        begin
          errc_r <= 7'h00;
          good_r <= 9'h000;
          if (hit_any) // see R03
          begin
            off_r <= hit_off;
            acq_r <= 5'h01;
            if (acq_thr == 5'h01)
            begin
              state_r <= ST_LOCK;
              rx_locked <= 1'b1; // see R04
            end
            else
              state_r <= ST_ACQ;
          end
        end
        ST_ACQ:
        begin
          if (grp_bad)
            state_r <= ST_HUNT; // see R06
          else if (grp_comma)
          begin
            acq_r <= acq_r + 5'h01;
            if (acq_r + 5'h01 >= acq_thr)
            begin
              state_r <= ST_LOCK;
              rx_locked <= 1'b1; // see R04 see R06
            end
          end
        end
        ST_LOCK:
        begin
          if (grp_bad)
          begin
            good_r <= 9'h000;
            if (errc_r + 7'h01 >= loss_thr) // see R05 see R19
            begin
              state_r <= ST_HUNT;
              rx_locked <= 1'b0;
              errc_r <= 7'h00;
            end
            else
              errc_r <= errc_r + 7'h01; // see R19
          end
          else if (good_r + 9'h001 >= good_thr) // see R02
          begin
            good_r <= 9'h000;
            if (errc_r != 7'h00)
              errc_r <= errc_r - 7'h01; // see R19
          end
          else
            good_r <= good_r + 9'h001;
        end
        default:
        begin
          state_r <= ST_HUNT;
          rx_locked <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Run-length check

  reg [7:0] rl_cnt_r;
  reg rl_bit_r;
  reg [1:0] rl_hold_r;
  reg [7:0] rl_cnt;
  reg rl_viol;
  reg [7:0] rl_thr;
  integer i;

  always @*
  begin
    rl_thr = w10 ? {ctrl_r[`RWA_F_RLV], 2'b00} + {3'b000, ctrl_r[`RWA_F_RLV]}
      + 8'd5 : {1'b0, ctrl_r[`RWA_F_RLV], 2'b00} + 8'd4; // see R09
    rl_cnt = rl_cnt_r;
    rl_viol = 1'b0;
    for (i = 9; i >= 0; i = i - 1)
    begin
      if (grp[i] == ((i == 9) ? rl_bit_r : grp[i+1]))
      begin
        if (rl_cnt != 8'hFF)
          rl_cnt = rl_cnt + 8'h01;
      end
      else
        rl_cnt = 8'h01;
      if (rl_cnt >= rl_thr)
        rl_viol = 1'b1; // see R07
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      rl_cnt_r <= 8'h00;
      rl_bit_r <= 1'b0;
      rl_hold_r <= 2'b00;
      rx_runlen <= 1'b0;
    end
    else if (word_ev)
    begin
      rl_cnt_r <= rl_cnt;
      rl_bit_r <= grp[0];
      if (rl_viol)
      begin
        rx_runlen <= 1'b1;
        rl_hold_r <= `RWA_RLV_HOLD; // see R08
      end
      else if (rl_hold_r > 2'b01)
        rl_hold_r <= rl_hold_r - 2'b01;
      else
      begin
        rl_hold_r <= 2'b00;
        rx_runlen <= 1'b0; // see R08
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate match buffer

  reg [9:0] mem [0:DEPTH-1];
  reg [4:0] wr_ptr_r;
  reg [4:0] rd_ptr_r;
  reg [7:0] tick_cnt_r;
  reg del_pend_r;
  reg [9:0] head;

  wire tick = (tick_cnt_r == WORD_DIV - 1);
  wire full = (level_r == DEPTH);
  wire empty = (level_r == 5'h00);
  wire is_skip = (grp == SKIP_CODE); // see R20
  wire take = word_ev & (rx_locked | ~rm_en); // see R14
  wire drop = take & rm_en & is_skip & (level_r >= `RWA_HI_MARK); // see R12
  wire push = take & ~drop & ~full;
  wire rep = tick & rm_en & ~empty & (level_r <= `RWA_LO_MARK) &
    (mem[rd_ptr_r] == SKIP_CODE); // see R11 see R20
  wire pop = tick & ~empty & ~rep;

  always @*
  begin
    head = mem[rd_ptr_r];
  end

  wire [7:0] out_dat;
  wire out_ctl;
  wire out_bad;

  rwa_dec_8b10b u_dec (
    .code(head),
    .data(out_dat),
    .ctrl(out_ctl),
    .err(out_bad)
  );

  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_r] <= grp; // see R13
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_r <= 5'h00;
      rd_ptr_r <= 5'h00;
      level_r <= 5'h00;
      tick_cnt_r <= 8'h00;
      del_pend_r <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      rx_ctrl <= 1'b0;
      rx_err <= 1'b0;
      rx_skip_del <= 1'b0;
      rx_skip_ins <= 1'b0;
    end
    else
    begin
      tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
      if (push)
        wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? 5'h00 : wr_ptr_r + 5'h01;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? 5'h00 : rd_ptr_r + 5'h01;
      level_r <= level_r + {4'h0, push} - {4'h0, pop}; // see R10 see R13
      rx_valid <= pop | rep;
      if (pop | rep)
      begin
        rx_data <= out_dat; // see R16
        rx_ctrl <= out_ctl;
        rx_err <= out_bad;
      end
      rx_skip_ins <= rep; // see R18
      rx_skip_del <= (pop | rep) & (del_pend_r | drop); // see R18
      if (drop)
        del_pend_r <= 1'b1;
      else if (pop | rep)
        del_pend_r <= 1'b0;
    end
  end

endmodule // rwa_top

/* dv/rwa_top_assertions.sv */
`timescale 1ns/1ps
module rwa_top_assertions (
  input wire clk,
  input wire reset,
  input wire rx_rclk,
  input wire [7:0] rx_data,
  input wire rx_ctrl,
  input wire rx_err,
  input wire rx_valid,
  input wire rx_locked,
  input wire rx_runlen,
  input wire rx_skip_del,
  input wire rx_skip_ins
);
  logic rclk_r;
  logic [3:0] since_r;
  logic [7:0] rises_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Link words seen since reset or loss, and age of the last one
  always @(posedge clk)
  begin
    rclk_r <= rx_rclk;
    if (reset || (rx_rclk && !rclk_r))
      since_r <= 4'h0;
    else if (since_r != 4'hF)
      since_r <= since_r + 4'h1;
    if (reset || $fell(rx_locked))
      rises_r <= 8'h00;
    else if (rx_rclk && !rclk_r && rises_r != 8'hFF)
      rises_r <= rises_r + 8'h01;
  end
  ////////////////////////////////////////
  property p_lock_acq;
    $rose(rx_locked) |-> rises_r >= 8'h03 && since_r <= 4'h6;
  endproperty
  a_lock_acq: assert property (p_lock_acq)
    else $error("locked rose without enough link words");
  property p_lock_loss;
    $fell(rx_locked) |-> since_r <= 4'h6;
  endproperty
  a_lock_loss: assert property (p_lock_loss)
    else $error("locked fell away from a link word");
  property p_relock;
    $fell(rx_locked) |=> !rx_locked [*8];
  endproperty
  a_relock: assert property (p_relock)
    else $error("locked came back too soon");
  property p_rlv_hold;
    $rose(rx_runlen) |=> rx_runlen [*8] ##1 rx_runlen [*7];
  endproperty
  a_rlv_hold: assert property (p_rlv_hold)
    else $error("run length flag too short");
  property p_valid_gap;
    rx_valid |=> !rx_valid [*7];
  endproperty
  a_valid_gap: assert property (p_valid_gap)
    else $error("output words too close");
  property p_ins;
    rx_skip_ins |-> rx_valid && rx_ctrl && rx_data == 8'h1C;
  endproperty
  a_ins: assert property (p_ins)
    else $error("inserted word is not a skip");
  property p_del;
    rx_skip_del |-> rx_valid;
  endproperty
  a_del: assert property (p_del)
    else $error("deletion flag without output word");
  property p_kchar;
    rx_valid && rx_ctrl && !rx_err |->
      rx_data[4:0] == 5'h1C || rx_data[7:5] == 3'h7;
  endproperty
  a_kchar: assert property (p_kchar)
    else $error("control flag on a data byte");
  c_lock: cover property ($rose(rx_locked));
  c_ins: cover property (rx_skip_ins);
  c_del: cover property (rx_skip_del);
  c_rlv: cover property ($rose(rx_runlen));
endmodule // rwa_top_assertions

/* dv/rwa_link_model.sv */
`timescale 1ns/1ps
module rwa_link_model (
  output logic rx_rclk,
  output logic [9:0] rx_code
);
  logic [9:0] q[$];
  int half_ns = 400;
  // Clock stands still between words; idle data keeps toggling
  initial
  begin
    rx_rclk = 1'h0;
    rx_code = 10'h2AA;
    #37;
    forever
    begin
      if (q.size() == 0)
      begin
        rx_code = ~rx_code;
        #(half_ns);
      end
      else
      begin
        rx_code = q.pop_front();
        #(half_ns);
        rx_rclk = 1'h1;
        #(half_ns);
        rx_rclk = 1'h0;
      end
    end
  end
endmodule // rwa_link_model

/* dv/tb_rwa_top.sv */
`timescale 1ns/1ps
module tb_rwa_top;
  logic clk;
  logic reset;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire rx_rclk;
  wire [9:0] rx_code;
  wire [7:0] rx_data;
  wire rx_ctrl, rx_err, rx_valid, rx_locked;
  wire rx_runlen, rx_skip_del, rx_skip_ins;
  int error_cnt = 0;
  int checked = 0;
  int n_out = 0;
  int n_ins = 0;
  int n_del = 0;
  logic [9:0] last = 10'h000;
  logic [31:0] v;
  rwa_link_model link (.rx_rclk(rx_rclk), .rx_code(rx_code));
  rwa_top DUT (
    .clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_rclk(rx_rclk), .rx_code(rx_code), .rx_data(rx_data),
    .rx_ctrl(rx_ctrl), .rx_err(rx_err), .rx_valid(rx_valid),
    .rx_locked(rx_locked), .rx_runlen(rx_runlen),
    .rx_skip_del(rx_skip_del), .rx_skip_ins(rx_skip_ins)
  );
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
    if (rx_valid === 1'h1)
    begin
      last <= {rx_err, rx_ctrl, rx_data};
      n_out <= n_out + 1;
      n_ins <= n_ins + int'(rx_skip_ins);
      n_del <= n_del + int'(rx_skip_del);
    end
  ////////////////////////////////////////
  task automatic summarize();
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'h0);
    v = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic snd(input logic [9:0] c, input int n);
    repeat (n) link.q.push_back(c);
    while (link.q.size() != 0) @(posedge clk);
    repeat (20) @(posedge clk);
  endtask
  task automatic rst();
    reset <= 1'h1;
    repeat (4) @(posedge clk);
    reset <= 1'h0;
  endtask
  initial
  begin
    #1_000_000;
    error_cnt++;
    summarize();
  end
  ////////////////////////////////////////
  initial
  begin
    reset = 1'h1;
    avs_address = 4'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    rst();
    bus(1'h0, 4'h0, 32'h0000_0000, 4'h0);
    chk("ctrl", 32'h03FC_83C3, v);
    bus(1'h0, 4'hC, 32'h0000_0000, 4'h0);
    chk("unmapped", 32'h0000_0000, v);
    snd(10'h2AA, 3);
    chk("prelock_out", 32'h0000_0000, n_out);
    bus(1'h1, 4'h0, 32'h0080_0000, 4'h4);
    bus(1'h0, 4'h0, 32'h0000_0000, 4'h0);
    chk("ctrl_rlv", 32'h0380_83C3, v);
    snd(10'h3C3, 1);
    chk("runlen_4", 32'h0000_0000, 32'(rx_runlen));
    snd(10'h2BE, 1);
    chk("runlen_5", 32'h0000_0001, 32'(rx_runlen));
    bus(1'h1, 4'h0, 32'h0200_0000, 4'h8);
    snd(10'h0FA, 1);
    chk("dec_k", 32'h0000_01BC, 32'(last));
    snd(10'h2AA, 1);
    chk("dec_d", 32'h0000_00B5, 32'(last));
    rst();
    snd(10'h0FA, 2);
    chk("lock_2", 32'h0000_0000, 32'(rx_locked));
    snd(10'h0FA, 1);
    chk("lock_3", 32'h0000_0001, 32'(rx_locked));
    bus(1'h0, 4'h4, 32'h0000_0000, 4'h0);
    chk("stat_lock", 32'h0000_0001, 32'(v[0]));
    snd(10'h2AF, 3);
    snd(10'h2AA, 16);
    snd(10'h2AF, 1);
    chk("lock_hold", 32'h0000_0001, 32'(rx_locked));
    bus(1'h0, 4'h4, 32'h0000_0000, 4'h0);
    chk("err_cnt", 32'h0000_0003, 32'(v[13:7]));
    snd(10'h2AF, 1);
    chk("lock_loss", 32'h0000_0000, 32'(rx_locked));
    snd(10'h0FA, 2);
    chk("relock_2", 32'h0000_0000, 32'(rx_locked));
    snd(10'h0FA, 1);
    chk("relock_3", 32'h0000_0001, 32'(rx_locked));
    link.half_ns = 600;
    snd(10'h0F4, 4);
    chk("skip_ins", 32'h0000_0001, 32'(n_ins > 0));
    link.half_ns = 200;
    for (int i = 0; i < 20; i++)
    begin
      link.q.push_back(10'h2AA);
      link.q.push_back(10'h0F4);
    end
    repeat (140) @(posedge clk);
    bus(1'h0, 4'h4, 32'h0000_0000, 4'h0);
    chk("fill", 32'h0000_0001, 32'(v[6:2] inside {[12:16]}));
    snd(10'h2AA, 1);
    chk("skip_del", 32'h0000_0001, 32'(n_del > 0));
    link.half_ns = 400;
    summarize();
  end
endmodule // tb_rwa_top

bind rwa_top rwa_top_assertions u_sva (
  .clk(clk),
  .reset(reset),
  .rx_rclk(rx_rclk),
  .rx_data(rx_data),
  .rx_ctrl(rx_ctrl),
  .rx_err(rx_err),
  .rx_valid(rx_valid),
  .rx_locked(rx_locked),
  .rx_runlen(rx_runlen),
  .rx_skip_del(rx_skip_del),
  .rx_skip_ins(rx_skip_ins)
);
